// ### verilog/rtc_pkg.sv
`default_nettype none
package rtc_pkg;
    // ****************************************************
    // bus and register map
    // ****************************************************
    localparam int RTC_AW = 16;
    // printed offsets are register indices; byte address is four times the index
    localparam logic [13:0] RTC_IDX_STAT = 14'h306A;
    localparam logic [13:0] RTC_IDX_CTL = 14'h306B;
    localparam logic [13:0] RTC_IDX_LIM_HI = 14'h306C;
    localparam logic [13:0] RTC_IDX_LIM_LO = 14'h306D;
    localparam logic [13:0] RTC_IDX_CNT_HI = 14'h306E;
    localparam logic [13:0] RTC_IDX_CNT_LO = 14'h306F;
    localparam logic [1:0] RTC_RESP_OKAY = 2'h0;
    localparam logic [1:0] RTC_RESP_SLVERR = 2'h2;

    // ****************************************************
    // field positions and reset values
    // ****************************************************
    localparam int RTC_FLAG_BIT = 7;
    localparam int RTC_IEN_BIT = 6;
    localparam int RTC_SRC_MSB = 7;
    localparam int RTC_SRC_LSB = 6;
    localparam int RTC_PS_MSB = 2;
    localparam logic [1:0] RTC_SRC_EXT = 2'h0;
    localparam logic [1:0] RTC_SRC_LP = 2'h1;
    localparam logic [1:0] RTC_SRC_RST = 2'h0;
    localparam logic [2:0] RTC_PS_OFF = 3'h0;
    localparam logic [2:0] RTC_PS_RST = 3'h0;
    localparam logic [15:0] RTC_MOD_RST = 16'h0000;

    // ****************************************************
    // divide values per prescaler code
    // ****************************************************
    localparam int RTC_DIVW = 11;
    localparam logic [11:0] RTC_DIV_X0 [0:7] = '{12'h000, 12'h001, 12'h002, 12'h004,
                                                 12'h008, 12'h010, 12'h020, 12'h040};
    localparam logic [11:0] RTC_DIV_X1 [0:7] = '{12'h000, 12'h080, 12'h100, 12'h200,
                                                 12'h400, 12'h800, 12'h064, 12'h3E8};

    // ****************************************************
    // bus carriers
    // ****************************************************
    typedef struct packed {
        logic awvalid;
        logic [RTC_AW-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [RTC_AW-1:0] araddr;
        logic rready;
    } rtc_axil_req_type;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } rtc_axil_rsp_type;
endpackage
`default_nettype wire

// ### verilog/rtc_edge_sync.sv
`timescale 1ns/1ps
`default_nettype none
module rtc_edge_sync (
    input wire logic aclk, // bus clock
    input wire logic aresetn, // synchronous reset, active low
    input wire logic pin, // asynchronous source clock
    output logic rise // one pulse per rising edge of pin
);
    import rtc_pkg::*;

    typedef struct packed {
        logic [2:0] pipe;
        logic rise;
    } rtc_sync_state_type;

    rtc_sync_state_type st;
    rtc_sync_state_type next_st;

    // first stage feeds only the second; edge taken after stage two
    always_comb begin
        next_st = st;
        next_st.pipe = {st.pipe[1:0], pin};
        next_st.rise = st.pipe[1] & ~st.pipe[2];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rise = st.rise;
endmodule
`default_nettype wire

// ### verilog/rtc_divider.sv
`timescale 1ns/1ps
`default_nettype none
module rtc_divider (
    input wire logic aclk, // bus clock
    input wire logic aresetn, // synchronous reset, active low
    input wire logic clear, // restart the divider
    input wire logic src_pulse, // one pulse per source clock edge
    input wire logic src_hi, // low bit of the source select
    input wire logic [2:0] code, // divider select code
    output logic tick // one pulse per divided period
);
    import rtc_pkg::*;

    typedef struct packed {
        logic [RTC_DIVW-1:0] cnt;
        logic tick;
    } rtc_div_state_type;

    rtc_div_state_type st;
    rtc_div_state_type next_st;
    logic [11:0] divisor;

    always_comb begin
        next_st = st;
        divisor = src_hi ? RTC_DIV_X1[code] : RTC_DIV_X0[code];
        next_st.tick = 1'b0;
        if (clear || code == RTC_PS_OFF) begin
            next_st.cnt = '0;
        end else if (src_pulse) begin
            if (st.cnt == RTC_DIVW'(divisor - 12'h001)) begin
                next_st.cnt = '0;
                next_st.tick = 1'b1;
            end else begin
                next_st.cnt = st.cnt + RTC_DIVW'(1);
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick = st.tick;
endmodule
`default_nettype wire

// ### verilog/rtc_core.sv
// Summary of operation
// - two-bit source select: oscillator, low-power, bus
// - changed source clears divider and count
// - reset selects the external oscillator
// - control bits five to three read zero
// - code zero off; low bit zero: binary divides
// - low bit one: large binary or decimal divides
// - changed divider code clears divider and count
// - reset turns divider off, counter idle
// - match resets count and sets match flag
// - zero modulo flags every divider tick
// - reset zeroes both modulo bytes
// - low count read locks high byte snapshot
// - count registers read only, writes ignored
// - count clears on reset or select change
// - flag sets on wrap back to zero
// - modulo takes effect at wrap or start
// - flag cleared by writing one only
// - interrupt while flag and enable set
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module rtc_core (
    input wire logic aclk, // bus clock, 250 MHz
    input wire logic aresetn, // synchronous reset, active low
    input wire rtc_pkg::rtc_axil_req_type axi_req, // bus requests
    output var rtc_pkg::rtc_axil_rsp_type axi_rsp, // bus answers
    input wire logic ext_osc_clk, // external oscillator pin
    input wire logic lp_osc_clk, // low-power oscillator pin
    output logic irq // match interrupt request
);
    import rtc_pkg::*;

    // ****************************************************
    // state
    // ****************************************************
    typedef struct packed {
        rtc_axil_rsp_type rsp;
        logic aw_held;
        logic [13:0] aw_idx;
        logic w_held;
        logic [7:0] w_byte;
        logic w_lane;
        logic [1:0] src;
        logic [2:0] ps;
        logic [15:0] mod_buf;
        logic [15:0] mod_act;
        logic [15:0] count;
        logic [15:0] snap;
        logic flag;
        logic irq_en;
        logic irq;
    } rtc_core_state_type;

    rtc_core_state_type st;
    rtc_core_state_type next_st;

    logic ext_rise;
    logic lp_rise;
    logic src_pulse;
    logic tick;
    logic aw_take;
    logic w_take;
    logic ar_take;
    logic [13:0] ar_idx;
    logic wr_fire;
    logic wr_ctl;
    logic src_chg;
    logic ps_chg;
    logic div_clear;
    logic wrap;
    logic flag_clr;
    logic w_mapped;

    // ****************************************************
    // clock sources and divider
    // ****************************************************
    rtc_edge_sync u_ext_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin(ext_osc_clk),
        .rise(ext_rise)
    );

    rtc_edge_sync u_lp_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin(lp_osc_clk),
        .rise(lp_rise)
    );

    // 10 and 11 both run from the bus clock
    always_comb begin
        unique case (st.src)
            RTC_SRC_EXT: src_pulse = ext_rise;
            RTC_SRC_LP: src_pulse = lp_rise;
            default: src_pulse = 1'b1;
        endcase
    end

    rtc_divider u_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .clear(div_clear),
        .src_pulse(src_pulse),
        .src_hi(st.src[0]),
        .code(st.ps),
        .tick(tick)
    );

    // ****************************************************
    // decode
    // ****************************************************
    assign aw_take = axi_req.awvalid & st.rsp.awready;
    assign w_take = axi_req.wvalid & st.rsp.wready;
    assign ar_take = axi_req.arvalid & st.rsp.arready;
    assign ar_idx = axi_req.araddr[RTC_AW-1:2];
    assign wr_fire = st.aw_held & st.w_held;
    assign wr_ctl = wr_fire & st.w_lane & (st.aw_idx == RTC_IDX_CTL);
    assign src_chg = wr_ctl & (st.w_byte[RTC_SRC_MSB:RTC_SRC_LSB] != st.src);
    assign ps_chg = wr_ctl & (st.w_byte[RTC_PS_MSB:0] != st.ps);
    // equal values leave divider and count running
    assign div_clear = src_chg | ps_chg;
    // zero modulo matches on every tick, even if the count ran past it
    assign wrap = tick & ~div_clear & ((st.count == st.mod_act) | (st.mod_act == 16'h0000));
    assign flag_clr = wr_fire & st.w_lane & (st.aw_idx == RTC_IDX_STAT)
                      & st.w_byte[RTC_FLAG_BIT];
    assign w_mapped = (st.aw_idx >= RTC_IDX_STAT) && (st.aw_idx <= RTC_IDX_CNT_LO);

    // ****************************************************
    // next state
    // ****************************************************
    always_comb begin
        next_st = st;
        // write channel: address and data taken in either order
        if (aw_take) begin
            next_st.aw_held = 1'b1;
            next_st.aw_idx = axi_req.awaddr[RTC_AW-1:2];
        end
        if (w_take) begin
            next_st.w_held = 1'b1;
            next_st.w_byte = axi_req.wdata[7:0];
            next_st.w_lane = axi_req.wstrb[0];
        end
        if (wr_fire) begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.rsp.bvalid = 1'b1;
            next_st.rsp.bresp = w_mapped ? RTC_RESP_OKAY : RTC_RESP_SLVERR;
            if (st.w_lane) begin
                case (st.aw_idx)
                    RTC_IDX_STAT: begin
                        next_st.irq_en = st.w_byte[RTC_IEN_BIT];
                    end
                    RTC_IDX_CTL: begin
                        // reserved bits are not stored
                        next_st.src = st.w_byte[RTC_SRC_MSB:RTC_SRC_LSB];
                        next_st.ps = st.w_byte[RTC_PS_MSB:0];
                        if (st.w_byte[RTC_PS_MSB:0] != RTC_PS_OFF) begin
                            next_st.mod_act = st.mod_buf;
                        end
                    end
                    RTC_IDX_LIM_HI: begin
                        next_st.mod_buf[15:8] = st.w_byte;
                    end
                    RTC_IDX_LIM_LO: begin
                        next_st.mod_buf[7:0] = st.w_byte;
                    end
                    // count bytes take no writes
                    default: begin
                    end
                endcase
            end
        end
        if (st.rsp.bvalid && axi_req.bready) begin
            next_st.rsp.bvalid = 1'b0;
        end
        next_st.rsp.awready = ~next_st.aw_held & ~next_st.rsp.bvalid;
        next_st.rsp.wready = ~next_st.w_held & ~next_st.rsp.bvalid;

        // read channel
        if (ar_take) begin
            next_st.rsp.rvalid = 1'b1;
            next_st.rsp.rresp = RTC_RESP_OKAY;
            next_st.rsp.rdata = '0;
            case (ar_idx)
                RTC_IDX_STAT: begin
                    next_st.rsp.rdata[RTC_FLAG_BIT] = st.flag;
                    next_st.rsp.rdata[RTC_IEN_BIT] = st.irq_en;
                end
                RTC_IDX_CTL: begin
                    next_st.rsp.rdata[RTC_SRC_MSB:RTC_SRC_LSB] = st.src;
                    next_st.rsp.rdata[RTC_PS_MSB:0] = st.ps;
                end
                RTC_IDX_LIM_HI: begin
                    next_st.rsp.rdata[7:0] = st.mod_buf[15:8];
                end
                RTC_IDX_LIM_LO: begin
                    next_st.rsp.rdata[7:0] = st.mod_buf[7:0];
                end
                RTC_IDX_CNT_LO: begin
                    next_st.rsp.rdata[7:0] = st.count[7:0];
                    next_st.snap = st.count;
                end
                RTC_IDX_CNT_HI: begin
                    // high byte only coherent after a low byte read
                    next_st.rsp.rdata[7:0] = st.snap[15:8];
                end
                default: begin
                    next_st.rsp.rresp = RTC_RESP_SLVERR;
                end
            endcase
        end
        if (st.rsp.rvalid && axi_req.rready) begin
            next_st.rsp.rvalid = 1'b0;
        end
        next_st.rsp.arready = ~next_st.rsp.rvalid;

        // counter
        if (div_clear) begin
            next_st.count = '0;
        end else if (wrap) begin
            next_st.count = '0;
            next_st.mod_act = st.mod_buf;
        end else if (tick) begin
            next_st.count = st.count + 16'h0001;
        end

        // set wins over a same-cycle clear
        if (flag_clr) begin
            next_st.flag = 1'b0;
        end
        if (wrap) begin
            next_st.flag = 1'b1;
        end
        next_st.irq = next_st.flag & next_st.irq_en;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
            st.src <= RTC_SRC_RST;
            st.ps <= RTC_PS_RST;
            st.mod_buf <= RTC_MOD_RST;
            st.mod_act <= RTC_MOD_RST;
        end else begin
            st <= next_st;
        end
    end

    assign axi_rsp = st.rsp;
    assign irq = st.irq;

    // ****************************************************
    // checks
    // ****************************************************
    a_reset_defaults: assert property (@(posedge aclk)
        !aresetn |=> st.src == RTC_SRC_RST && st.ps == RTC_PS_RST
            && st.mod_buf == 16'h0000 && st.count == 16'h0000 && !st.flag)
        else $error("reset did not restore defaults");

    a_src_change_clr: assert property (@(posedge aclk) disable iff (!aresetn)
        src_chg |=> st.count == 16'h0000 && !tick)
        else $error("source change did not clear count");

    a_ps_change_clr: assert property (@(posedge aclk) disable iff (!aresetn)
        ps_chg |=> st.count == 16'h0000 && !tick)
        else $error("divider change did not clear count");

    a_rsvd_read_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        ar_take && ar_idx == RTC_IDX_CTL |=> st.rsp.rvalid && st.rsp.rdata[5:3] == 3'h0)
        else $error("reserved control bits read nonzero");

    a_off_no_tick: assert property (@(posedge aclk) disable iff (!aresetn)
        st.ps == RTC_PS_OFF && $past(st.ps) == RTC_PS_OFF |-> !tick)
        else $error("tick while divider off");

    a_match_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
        wrap |=> st.count == 16'h0000 && st.flag && st.mod_act == $past(st.mod_buf))
        else $error("match did not wrap count and set flag");

    a_mod_zero_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        tick && !div_clear && st.mod_act == 16'h0000 |=> st.flag)
        else $error("zero modulo missed flag on tick");

    a_count_step: assert property (@(posedge aclk) disable iff (!aresetn)
        tick && !div_clear && !wrap
            |=> st.count == $past(st.count) + 16'h0001
                && (st.flag == $past(st.flag) || $past(flag_clr)))
        else $error("count did not step on tick");

    a_count_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        !tick && !div_clear |=> $stable(st.count))
        else $error("count moved without a tick");

    a_snap_lock: assert property (@(posedge aclk) disable iff (!aresetn)
        ar_take && ar_idx == RTC_IDX_CNT_LO
            |=> st.snap == $past(st.count) && st.rsp.rdata[7:0] == $past(st.count[7:0]))
        else $error("low count read did not lock snapshot");

    a_snap_high: assert property (@(posedge aclk) disable iff (!aresetn)
        ar_take && ar_idx == RTC_IDX_CNT_HI |=> st.rsp.rdata[7:0] == st.snap[15:8])
        else $error("high count read not from snapshot");

    a_flag_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        st.flag && !flag_clr && !wrap |=> st.flag)
        else $error("match flag lost without a one written");

    a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
        irq == (st.flag && st.irq_en))
        else $error("interrupt missing while flag and enable set");
endmodule
`default_nettype wire

// ### testbench/rtc_prescale_modulo_counter_test.sv
`timescale 1ns/1ps
`default_nettype none
module rtc_prescale_modulo_counter_test;
    import rtc_pkg::*;
    // ****************************************************
    // addresses and bench state
    // ****************************************************
    localparam logic [15:0] A_STAT = {RTC_IDX_STAT, 2'b00};
    localparam logic [15:0] A_CTL = {RTC_IDX_CTL, 2'b00};
    localparam logic [15:0] A_MH = {RTC_IDX_LIM_HI, 2'b00};
    localparam logic [15:0] A_ML = {RTC_IDX_LIM_LO, 2'b00};
    localparam logic [15:0] A_CH = {RTC_IDX_CNT_HI, 2'b00};
    localparam logic [15:0] A_CL = {RTC_IDX_CNT_LO, 2'b00};
    localparam logic [15:0] A_BAD = 16'hC1C0;
    logic aclk;
    logic aresetn;
    rtc_axil_req_type req;
    rtc_axil_rsp_type rsp;
    logic ext_osc_clk;
    logic lp_osc_clk;
    logic irq;
    int fail_count;
    int n_compared;
    int cyc;
    int osc_cnt;
    logic [31:0] rd;
    logic [1:0] rs;

    rtc_core dut_u (
        .aclk(aclk),
        .aresetn(aresetn),
        .axi_req(req),
        .axi_rsp(rsp),
        .ext_osc_clk(ext_osc_clk),
        .lp_osc_clk(lp_osc_clk),
        .irq(irq)
    );

    // ****************************************************
    // shared tasks
    // ****************************************************
    task automatic chk(input bit ok, input string msg);
        n_compared++;
        if (!ok) begin
            fail_count++;
            $display("ERROR at %0t: %s", $time, msg);
        end
    endtask

    task automatic conclude;
        $display("checks %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // address and data offered together, each dropped once taken
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        bit b;
        b = 1'b0;
        @(posedge aclk);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= {24'h000000, d};
        req.wstrb <= 4'hF;
        req.bready <= 1'b1;
        while (!b) begin
            @(posedge aclk);
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
            if (req.bready && rsp.bvalid) begin
                rs = rsp.bresp;
                req.bready <= 1'b0;
                b = 1'b1;
            end
        end
    endtask

    task automatic rdr(input logic [15:0] a);
        bit b;
        b = 1'b0;
        @(posedge aclk);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        while (!b) begin
            @(posedge aclk);
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
            if (req.rready && rsp.rvalid) begin
                rd = rsp.rdata;
                rs = rsp.rresp;
                req.rready <= 1'b0;
                b = 1'b1;
            end
        end
    endtask

    task automatic rdchk(input logic [15:0] a, input logic [7:0] e, input string msg);
        rdr(a);
        chk(rd === {24'h000000, e} && rs === RTC_RESP_OKAY, msg);
    endtask

    task automatic wait_irq(input int lim, output int n);
        n = 0;
        while (irq !== 1'b1 && n < lim) begin
            @(posedge aclk);
            n++;
        end
    endtask

    function automatic int div_of(input logic hi, input int code);
        if (!hi) return 1 << (code - 1);
        if (code <= 5) return 128 << (code - 1);
        return (code == 6) ? 100 : 1000;
    endfunction

    // ****************************************************
    // scenarios
    // ****************************************************
    task automatic t_reset;
        logic [15:0] regs [6];
        regs = '{A_STAT, A_CTL, A_MH, A_ML, A_CH, A_CL};
        foreach (regs[i]) rdchk(regs[i], 8'h00, "reset value");
        repeat (50) @(posedge aclk);
        rdchk(A_CL, 8'h00, "count moved while off");
        wr(A_CTL, 8'h38);
        rdchk(A_CTL, 8'h00, "reserved control bits");
        rdr(A_BAD);
        chk(rs === RTC_RESP_SLVERR, "unmapped read resp");
        wr(A_BAD, 8'h5A);
        chk(rs === RTC_RESP_SLVERR, "unmapped write resp");
        $display("test reset done");
    endtask

    // every nonzero code on both bus-clock selects and code one on both pins, counted over eight divided periods
    task automatic t_rates;
        int t;
        int w;
        int ep;
        logic [7:0] c;
        wr(A_MH, 8'hFF);
        wr(A_ML, 8'hFF);
        for (int k = 0; k < 16; k++) begin
            if (k < 14) begin
                c = {(k < 7) ? 2'b10 : 2'b11, 3'b000, 3'(k % 7 + 1)};
                ep = 1;
            end else begin
                c = (k == 14) ? 8'h01 : 8'h41;
                ep = (k == 14) ? 10 : 4;
            end
            t = ep * div_of(c[6], int'(c[2:0]));
            w = 8 * t;
            wr(A_CTL, c);
            repeat (w + 8) @(posedge aclk);
            rdr(A_CL);
            chk(rd >= (w - 2 * ep + 2) / t && rd <= (w + 16 + 4 * ep) / t, "tick rate");
        end
        $display("test rates done");
    endtask

    task automatic t_match;
        int n;
        wr(A_MH, 8'h00);
        wr(A_ML, 8'h03);
        wr(A_STAT, 8'h40);
        wr(A_CTL, 8'h87);
        wait_irq(400, n);
        chk(n >= 240 && n <= 275, "first wrap time");
        rdchk(A_CL, 8'h00, "count after wrap");
        wr(A_ML, 8'h07);
        wr(A_STAT, 8'h40);
        rdchk(A_STAT, 8'hC0, "flag after write zero");
        chk(irq === 1'b1, "irq with flag and enable");
        wr(A_STAT, 8'hC0);
        @(posedge aclk);
        chk(irq === 1'b0, "irq after flag clear");
        wait_irq(400, n);
        chk(n > 150 && n < 260, "held modulo not yet used");
        wr(A_STAT, 8'hC0);
        wait_irq(700, n);
        chk(n > 470 && n < 520, "new modulo after wrap");
        wr(A_ML, 8'h00);
        wr(A_CTL, 8'h86);
        for (int k = 0; k < 2; k++) begin
            wr(A_STAT, 8'hC0);
            wait_irq(100, n);
            chk(n <= 40, "zero modulo flags each tick");
        end
        wr(A_STAT, 8'h80);
        $display("test match done");
    endtask

    task automatic t_count;
        logic [31:0] l;
        wr(A_MH, 8'hFF);
        wr(A_ML, 8'hFF);
        wr(A_CTL, 8'h81);
        rdr(A_CL);
        chk(rd < 32, "live low byte");
        repeat (300) @(posedge aclk);
        rdchk(A_CH, 8'h00, "high byte not from snapshot");
        rdr(A_CL);
        rdchk(A_CH, 8'h01, "second snapshot high byte");
        wr(A_CTL, 8'h87);
        repeat (640) @(posedge aclk);
        rdr(A_CL);
        l = rd;
        chk(rd >= 9 && rd <= 11, "count steps per tick");
        wr(A_CL, 8'h00);
        chk(rs === RTC_RESP_OKAY, "count write resp");
        wr(A_CH, 8'h00);
        rdr(A_CL);
        chk(rd >= l && rd <= l + 1, "count write disturbed count");
        wr(A_CTL, 8'h87);
        rdr(A_CL);
        chk(rd >= l && rd <= l + 1, "same select disturbed count");
        wr(A_CTL, 8'h86);
        rdr(A_CL);
        chk(rd <= 1, "new divider code kept count");
        repeat (200) @(posedge aclk);
        wr(A_CTL, 8'hC6);
        rdr(A_CL);
        chk(rd === 32'h00000000, "new source kept count");
        rdchk(A_CTL, 8'hC6, "control readback");
        $display("test count done");
    endtask

    // ****************************************************
    // clock, oscillator pins, timeout and main sequence
    // ****************************************************
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    // pin sources: rising edge every 10 and every 4 bus cycles
    always @(posedge aclk) begin
        osc_cnt <= osc_cnt + 1;
        if (osc_cnt % 5 == 4) ext_osc_clk <= ~ext_osc_clk;
        if (osc_cnt % 2 == 1) lp_osc_clk <= ~lp_osc_clk;
    end

    // the full run needs about 48000 cycles
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            fail_count++;
            $display("ERROR at %0t: timeout", $time);
            conclude;
        end
    end

    initial begin
        req = '0;
        aresetn = 1'b0;
        ext_osc_clk = 1'b0;
        lp_osc_clk = 1'b0;
        osc_cnt = 0;
        cyc = 0;
        fail_count = 0;
        n_compared = 0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_reset;
        t_rates;
        t_match;
        t_count;
        conclude;
    end
endmodule
`default_nettype wire
